//--- src/cdt_defs.vh
// Constants for the cable driver test pattern controller.
// Assumes inclusion by bare name from design files under src/.
`ifndef CDT_DEFS_VH
`define CDT_DEFS_VH
// ==================================================================
// Register map (Avalon word addresses)
`define CDT_ADDR_CTRL      2'h0
`define CDT_ADDR_STATUS    2'h1
// ==================================================================
// Control register fields
`define CDT_BIT_PDN        15
`define CDT_BIT_DCD        14
`define CDT_BIT_SQW        13
`define CDT_BIT_RISE       11
`define CDT_BIT_FALL       9
`define CDT_BIT_TEST       8
`define CDT_BIT_SLOW       4
`define CDT_BIT_FAST       3
`define CDT_BIT_GAP        2
`define CDT_RW_MASK        16'hEB1F
`define CDT_CTRL_RESET     16'h8000
// ==================================================================
// Timing
`define CDT_CLK_MHZ        250
`define CDT_GAP_SHORT_US   10
`define CDT_GAP_LONG_US    15
`define CDT_GAP_SHORT_CYC  (`CDT_GAP_SHORT_US * `CDT_CLK_MHZ)
`define CDT_GAP_LONG_CYC   (`CDT_GAP_LONG_US * `CDT_CLK_MHZ)
`define CDT_SLOW_BIT_CYC   25
`define CDT_FAST_BIT_CYC   2
`define CDT_DATA_BITS      64
`define CDT_END_OF_PACKET_VARIANT_ZERO_HALVES    8
`define CDT_END_OF_PACKET_VARIANT_ONE_HALVES    12
`define CDT_NLP_CYC        25
`endif

//--- src/cdt_fast_gen.v
// Fast speed fixed bit pattern generator.
// Assumes a bit strobe from the parent; pattern select held stable.
`timescale 1ns/1ns
`default_nettype none
module cdt_fast_gen
(
  input  wire       clk,
  input  wire       rst,
  input  wire       en,
  input  wire       bit_stb,
  input  wire [1:0] sel,
  output reg        bit_out
);
  // ================================================================
  // Position counter within a 20 bit frame
  reg [4:0] pos_reg;
  reg [4:0] pos_next;
  reg       bit_next;

  // Pattern selection per position
  always @*
  begin
    pos_next = (pos_reg == 5'h13) ? 5'h00 : pos_reg + 5'h01;
    case (sel)
      2'h0: bit_next = 1'b0;                 // True quiet
      2'h1: bit_next = 1'b1;                 // All ones
      2'h2: bit_next = ~pos_reg[1];          // Two ones, two zeros
      default: bit_next = (pos_reg < 5'h0E); // Fourteen ones, six zeros
    endcase
  end

  // Advance on every bit strobe while enabled
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_reg <= 5'h00;
      bit_out <= 1'b0;
    end
    else if (!en)
    begin
      pos_reg <= 5'h00;
      bit_out <= 1'b0;
    end
    else if (bit_stb)
    begin
      bit_out <= bit_next;
      pos_reg <= (sel == 2'h2 && pos_reg == 5'h03) ? 5'h00 : pos_next;
    end
  end
endmodule // cdt_fast_gen
`default_nettype wire

//--- src/cdt_slow_gen.v
// Slow speed sequence generator: data plus end of packet, link pulses,
// constant Manchester ones; a selectable gap follows data and pulses only.
// Assumes gap counts are given by the parent in clock cycles.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_defs.vh"
module cdt_slow_gen
#(
  parameter GAP_SHORT = 2500,
  parameter GAP_LONG  = 3750
)
(
  input  wire       clk,
  input  wire       rst,
  input  wire       en,
  input  wire [1:0] sel,
  input  wire       gap_long,
  output reg        tx_out,
  output reg        tx_idle
);
  // ================================================================
  // States
  localparam S_IDLE = 2'h0;
  localparam S_SEND = 2'h1;
  localparam S_EOP  = 2'h2;
  localparam S_GAP  = 2'h3;

  reg [1:0]  state_reg;             // Sequencer state
  reg [13:0] cnt_reg;               // Cycle counter
  reg [6:0]  half_reg;              // Half bit counter
  reg        phase_reg;             // Manchester phase
  wire       half_end = (cnt_reg == `CDT_SLOW_BIT_CYC - 1);
  wire [31:0] eop_len_w = sel[0] ? `CDT_END_OF_PACKET_VARIANT_ONE_HALVES : `CDT_END_OF_PACKET_VARIANT_ZERO_HALVES; // Variant length
  wire [6:0]  eop_len   = eop_len_w[6:0];                                // Cut to counter width
  wire [13:0] gap_len = gap_long ? GAP_LONG[13:0] : GAP_SHORT[13:0];

  // Sequencer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= 14'h0000;
      half_reg  <= 7'h00;
      phase_reg <= 1'b0;
      tx_out    <= 1'b0;
      tx_idle   <= 1'b1;
    end
    else if (!en)
    begin
      state_reg <= S_IDLE;
      tx_out    <= 1'b0;
      tx_idle   <= 1'b1;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          // Start a sequence
          state_reg <= S_SEND;
          cnt_reg   <= 14'h0000;
          half_reg  <= 7'h00;
          phase_reg <= 1'b0;
          tx_idle   <= 1'b0;
          // Link pulse rises here so gap and pulse keep exact length
          if (sel == 2'h2)
            tx_out  <= 1'b1;
        end
        S_SEND:
        begin
          cnt_reg <= half_end ? 14'h0000 : cnt_reg + 14'h0001;
          if (sel == 2'h3)
          begin
            // Constant Manchester ones: steady 5 MHz tone
            tx_out <= phase_reg;
            if (half_end)
              phase_reg <= ~phase_reg;
          end
          else if (sel == 2'h2)
          begin
            // Single link pulse then gap
            tx_out <= 1'b1;
            if (cnt_reg == `CDT_NLP_CYC - 1)
            begin
              state_reg <= S_GAP;
              cnt_reg   <= 14'h0000;
              tx_out    <= 1'b0;
              tx_idle   <= 1'b1;
            end
          end
          else
          begin
            // Manchester data, alternating bit values
            tx_out <= phase_reg ^ half_reg[1];
            if (half_end)
            begin
              phase_reg <= ~phase_reg;
              half_reg  <= half_reg + 7'h01;
              if (half_reg == 2 * `CDT_DATA_BITS - 1)
              begin
                state_reg <= S_EOP;
                half_reg  <= 7'h00;
                tx_out    <= 1'b1;                 // End of packet starts now
              end
            end
          end
        end
        S_EOP:
        begin
          // End of packet: held high for the variant length
          tx_out  <= 1'b1;
          cnt_reg <= half_end ? 14'h0000 : cnt_reg + 14'h0001;
          if (half_end)
          begin
            half_reg <= half_reg + 7'h01;
            if (half_reg == eop_len - 7'h01)
            begin
              state_reg <= S_GAP;
              tx_out    <= 1'b0;
              tx_idle   <= 1'b1;
            end
          end
        end
        default:
        begin
          // Quiet gap between sequences
          tx_out  <= 1'b0;
          cnt_reg <= cnt_reg + 14'h0001;
          // Idle cycle closes the gap, so leave one early
          if (cnt_reg >= gap_len - 14'h0002)
            state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cdt_slow_gen
`default_nettype wire

//--- src/cdt_ctrl.v
// Functional notes
// - Power-down bit tristates driver, default set
// - Bit 14 boosts duty distortion compensation
// - Bit 13 gives square wave waveshaper test
// - Edge selects reset from straps, writable
// - Bit 8 enables speed dependent test mode
// - Bit 4 enables slow speed sequences
// - Bit 3 enables fast speed patterns
// - Gap 15 us when set, else 10
// - Fast select: zeros, ones, 2/2, 14/6
// - Slow select: END_OF_PACKET_VARIANT_ZERO, END_OF_PACKET_VARIANT_ONE, pulses, tone
//
// Top of the cable driver test pattern controller with Avalon-MM slave.
// Assumes straps are stable around reset release and speed is a level.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_defs.vh"
module cdt_ctrl
#(
  parameter GAP_SHORT_CYC = `CDT_GAP_SHORT_CYC,
  parameter GAP_LONG_CYC  = `CDT_GAP_LONG_CYC
)
(
  input  wire        ref_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Straps and operating speed
  input  wire        strap_rise,
  input  wire        strap_fall,
  input  wire        speed_100,
  // Driver controls
  output reg         drv_data,
  output reg         drv_data_oe_n,
  output reg         drv_powerdown,
  output reg         duty_distortion_comp_boost,
  output reg         waveshaper_square_test,
  output reg         edge_rise_select,
  output reg         edge_fall_select,
  output reg         driver_test_enable,
  output reg         pattern_active
);
  // ================================================================
  // Control register and strap capture
  reg  [15:0] ctrl_reg;          // Control word
  reg         strap_done_reg;    // Straps captured after release
  reg         ack_reg;           // Answer phase of a bus access
  wire        acc = (avs_read | avs_write) & ~ack_reg;
  wire        wr  = avs_write & ~ack_reg & (avs_address == `CDT_ADDR_CTRL);

  // Byte lane merge of write data
  wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & `CDT_RW_MASK;
  wire [15:0] ctrl_next = (ctrl_reg & ~wmask) | (avs_writedata[15:0] & wmask);

  // ================================================================
  // Pattern enables resolved by current speed
  wire fast_en = ctrl_reg[`CDT_BIT_FAST] & speed_100;
  wire slow_en = ctrl_reg[`CDT_BIT_SLOW] & ~speed_100;
  wire fast_bit;
  wire slow_bit;
  wire slow_idle;
  reg  [0:0] stb_cnt_reg;        // Fast bit strobe divider
  wire fast_stb = (stb_cnt_reg == 1'b1);

  // Register writes, strap capture, access handshake
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg        <= `CDT_CTRL_RESET;
      strap_done_reg  <= 1'b0;
      ack_reg         <= 1'b0;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      stb_cnt_reg     <= 1'b0;
    end
    else
    begin
      stb_cnt_reg <= stb_cnt_reg + 1'b1;
      if (!strap_done_reg)
      begin
        // Edge selects take their defaults from straps
        strap_done_reg           <= 1'b1;
        ctrl_reg[`CDT_BIT_RISE]  <= strap_rise;
        ctrl_reg[`CDT_BIT_FALL]  <= strap_fall;
      end
      else if (wr)
        ctrl_reg <= ctrl_next;
      // One wait cycle, then answer
      ack_reg         <= acc;
      avs_waitrequest <= ~acc;
      if (acc && avs_read)
      begin
        case (avs_address)
          `CDT_ADDR_CTRL:   avs_readdata <= {16'h0000, ctrl_reg};
          `CDT_ADDR_STATUS: avs_readdata <= {29'h00000000, slow_idle, drv_data, pattern_active};
          default:          avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ================================================================
  // Pattern generators
  cdt_fast_gen u_fast
  (
    .clk     (ref_clk),
    .rst     (rst),
    .en      (fast_en),
    .bit_stb (fast_stb),
    .sel     (ctrl_reg[1:0]),
    .bit_out (fast_bit)
  );

  cdt_slow_gen
  #(
    .GAP_SHORT (GAP_SHORT_CYC),
    .GAP_LONG  (GAP_LONG_CYC)
  )
  u_slow
  (
    .clk      (ref_clk),
    .rst      (rst),
    .en       (slow_en),
    .sel      (ctrl_reg[1:0]),
    .gap_long (ctrl_reg[`CDT_BIT_GAP]),
    .tx_out   (slow_bit),
    .tx_idle  (slow_idle)
  );

  // ================================================================
  // Driver outputs, all registered
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      drv_data                   <= 1'b0;
      drv_data_oe_n              <= 1'b1;
      drv_powerdown              <= 1'b1;
      duty_distortion_comp_boost <= 1'b0;
      waveshaper_square_test     <= 1'b0;
      edge_rise_select           <= 1'b0;
      edge_fall_select           <= 1'b0;
      driver_test_enable         <= 1'b0;
      pattern_active             <= 1'b0;
    end
    else
    begin
      drv_powerdown              <= ctrl_reg[`CDT_BIT_PDN];
      drv_data_oe_n              <= ctrl_reg[`CDT_BIT_PDN];
      duty_distortion_comp_boost <= ctrl_reg[`CDT_BIT_DCD];
      waveshaper_square_test     <= ctrl_reg[`CDT_BIT_SQW];
      edge_rise_select           <= ctrl_reg[`CDT_BIT_RISE];
      edge_fall_select           <= ctrl_reg[`CDT_BIT_FALL];
      driver_test_enable         <= ctrl_reg[`CDT_BIT_TEST];
      pattern_active             <= fast_en | slow_en;
      // Current speed picks the source
      drv_data <= speed_100 ? fast_bit : slow_bit;
    end
  end
endmodule // cdt_ctrl
`default_nettype wire

//--- tb/cdt_ctrl_asserts.sv
// Port assertions for the cable driver test controller.
// Assumes a bind onto cdt_ctrl; one clock, async active-high reset.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_defs.vh"
module cdt_ctrl_asserts
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [1:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        speed_100,
  input wire logic        drv_data,
  input wire logic        drv_data_oe_n,
  input wire logic        drv_powerdown,
  input wire logic        duty_distortion_comp_boost,
  input wire logic        waveshaper_square_test,
  input wire logic        edge_rise_select,
  input wire logic        edge_fall_select,
  input wire logic        driver_test_enable,
  input wire logic        pattern_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Helper state
  logic [31:0] wd_q;    // Write data one cycle back
  logic [4:0]  sel_sh;  // Shadow of enables, gap, select
  logic [6:0]  run_cnt; // Cycles of steady fast pattern
  wire acc = avs_write && !avs_waitrequest && avs_address == `CDT_ADDR_CTRL;
  // Track accepted control writes and fast run length
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      wd_q <= 32'h0;
      sel_sh <= 5'h00;
      run_cnt <= 7'h00;
    end
    else
    begin
      wd_q <= avs_writedata;
      if (acc && avs_byteenable[0])
        sel_sh <= avs_writedata[4:0];
      if (acc || !(pattern_active && speed_100 && sel_sh[3]))
        run_cnt <= 7'h00;
      else if (run_cnt != 7'h7F)
        run_cnt <= run_cnt + 7'h01;
    end
  // ==========================================
  // Properties
  property p_copy(logic o, int b);
    acc && avs_byteenable[1] |=> o == wd_q[b];
  endproperty
  sequence s_fast(logic [1:0] s);
    run_cnt > 7'h08 && sel_sh[1:0] == s;
  endsequence
  sequence s_level;
    run_cnt > 7'h08 && !sel_sh[1];
  endsequence
  AST_PDN: assert property (p_copy(drv_powerdown, 15))
    else $error("power-down copy wrong");
  AST_OE: assert property (drv_data_oe_n == drv_powerdown)
    else $error("driver enable not tied to power-down");
  AST_DCD: assert property (p_copy(duty_distortion_comp_boost, 14))
    else $error("compensation copy wrong");
  AST_SQW: assert property (p_copy(waveshaper_square_test, 13))
    else $error("square test copy wrong");
  AST_RISE: assert property (p_copy(edge_rise_select, 11))
    else $error("rise select copy wrong");
  AST_FALL: assert property (p_copy(edge_fall_select, 9))
    else $error("fall select copy wrong");
  AST_TEST: assert property (p_copy(driver_test_enable, 8))
    else $error("test enable copy wrong");
  AST_ACTIVE: assert property (pattern_active == ($past(speed_100) ? sel_sh[3] : sel_sh[4]))
    else $error("pattern active wrong");
  AST_FAST_LEVEL: assert property (s_level |-> drv_data == sel_sh[0])
    else $error("fast level pattern wrong");
  AST_FAST_HALF: assert property (s_fast(2'h2) |-> drv_data != $past(drv_data, 4))
    else $error("fast two-two pattern wrong");
endmodule // cdt_ctrl_asserts
`default_nettype wire

//--- tb/cdt_cable_model.sv
// Cable model: line level seen through the transformer.
// Assumes registered driver outputs; released line shows stale inverse.
`timescale 1ns/1ns
`default_nettype none
module cdt_cable_model
(
  input wire logic ref_clk,
  input wire logic drv_data,
  input wire logic drv_data_oe_n,
  output logic     line
);
  logic last_reg = 1'b0; // Last driven level
  // Remember what was driven
  always @(posedge ref_clk)
    if (!drv_data_oe_n)
      last_reg <= drv_data;
  // Released line never shows the old value
  assign line = drv_data_oe_n ? ~last_reg : drv_data;
endmodule // cdt_cable_model
`default_nettype wire

//--- tb/cdt_ctrl_tb.sv
// Bench for the cable driver test controller.
// Assumes the checker and cable model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "cdt_defs.vh"
module cdt_ctrl_tb;
  localparam int GS = 20; // Short gap, cycles
  localparam int GL = 30; // Long gap, cycles
  logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic strap_rise = 1'b1, strap_fall = 1'b0, speed_100 = 1'b1;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, drv_data, drv_data_oe_n, drv_powerdown, line, pattern_active,
       duty_distortion_comp_boost, waveshaper_square_test, edge_rise_select,
       edge_fall_select, driver_test_enable;
  int err_total = 0, n_compared = 0, ones, run, gap;
  int fo[4] = '{0, 40, 20, 28};
  logic [15:0] d;
  cdt_ctrl #(.GAP_SHORT_CYC(GS), .GAP_LONG_CYC(GL)) dut (.ref_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .strap_rise, .strap_fall, .speed_100, .drv_data, .drv_data_oe_n,
    .drv_powerdown, .duty_distortion_comp_boost, .waveshaper_square_test,
    .edge_rise_select, .edge_fall_select, .driver_test_enable, .pattern_active);
  cdt_cable_model u_cable (.ref_clk, .drv_data, .drv_data_oe_n, .line);
  initial forever #2 ref_clk = ~ref_clk;
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [15:0] v,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, v};
    avs_byteenable <= 4'h3;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] v);
    logic [31:0] q;
    bus(1'b1, 2'h0, v, q);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    chk(q, exp);
  endtask
  // Ones, longest high run and rise spacing on the line
  task automatic measure(input int n);
    int r, lastr;
    logic prev;
    ones = 0; run = 0; gap = 0; r = 0; lastr = -1; prev = line;
    for (int t = 0; t < n; t++)
    begin
      @(posedge ref_clk);
      r = line ? r + 1 : 0;
      ones += line;
      if (r > run) run = r;
      if (line && !prev && lastr >= 0) gap = t - lastr;
      if (line && !prev) lastr = t;
      prev = line;
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reset with given straps
  task automatic do_reset(input logic sr, input logic sf);
    rst <= 1'b1;
    strap_rise <= sr;
    strap_fall <= sf;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    do_reset(1'b1, 1'b0);
    rdc(2'h0, 32'h8800);
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 16'h0000 : `CDT_RW_MASK;
      wr(d);
      rdc(2'h0, {16'h0, d & `CDT_RW_MASK});
      chk({drv_powerdown, duty_distortion_comp_boost, waveshaper_square_test,
           edge_rise_select, edge_fall_select, driver_test_enable, drv_data_oe_n},
          {d[15], d[14], d[13], d[11], d[9], d[8], d[15]});
    end
    rdc(2'h3, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr(16'h0000);
      wr(16'h0008 | s);
      chk(pattern_active, 1'b1);
      repeat (60) @(posedge ref_clk);
      measure(40);
      chk(ones, fo[s]);
    end
    wr(16'h0010);
    chk(pattern_active, 1'b0);
    speed_100 <= 1'b0;
    wr(16'h0013);
    measure(200);
    chk(run, 25);
    for (int g = 0; g < 2; g++)
    begin
      wr(16'h0000);
      wr(16'h0012 | (g << 2));
      measure(300);
      chk(gap, `CDT_NLP_CYC + (g ? GL : GS));
    end
    for (int v = 0; v < 2; v++)
    begin
      wr(16'h0000);
      wr(16'h0010 | v);
      measure(4000);
      chk(run, 25 * (v ? `CDT_END_OF_PACKET_VARIANT_ONE_HALVES : `CDT_END_OF_PACKET_VARIANT_ZERO_HALVES));
    end
    wr(16'h0000);
    chk(pattern_active, 1'b0);
    wr(16'h001B);
    measure(200);
    chk(run, 25);
    wr(16'h0000);
    speed_100 <= 1'b1;
    wr(16'h001B);
    measure(200);
    chk(run, 28);
    do_reset(1'b0, 1'b1);
    rdc(2'h0, 32'h8200);
    rdc(2'h1, 32'h4);
    tally_and_finish();
  end
endmodule // cdt_ctrl_tb
bind cdt_ctrl cdt_ctrl_asserts u_asserts (.ref_clk, .rst, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .speed_100, .drv_data,
  .drv_data_oe_n, .drv_powerdown, .duty_distortion_comp_boost, .waveshaper_square_test,
  .edge_rise_select, .edge_fall_select, .driver_test_enable, .pattern_active);
`default_nettype wire
